//--- pkg/ccm_cfg.svh
// ==========================================
// Operation
// - Mode zero disables the channel and returns its state and prescaler to reset.
// - Codes 0100-0111 capture on falling, rising, 4th or 16th rising edge; 0001/0011 reserved.
// - Code 0010 toggles the pin on each compare match and sets the flag.
// - Code 1000 drives the pin low on entry, high on match, sets the flag.
// - Code 1001 drives the pin high on entry, low on match, sets the flag.
// - Code 1010 only sets the flag on match; pin shows the port latch.
// - Code 1011 pulses special event (timer reset, conversion start) and sets the flag.
// - Codes 11xx are PWM; control bits 5:4 are duty bits 1:0, data low is 9:2.
// - Data register pair of two readable, writable bytes beside the control register.
// - Capture/compare use one 16-bit timer, PWM one 8-bit period timer, per assignment.
// - Up to four timers active; channels of one kind share a common timer.
// - Assignment cases: all first pair, channel 0 only, channels 0-1, all second pair.
// - Open-drain bit makes the pin open-drain while it drives in compare or PWM.
// - Open-drain register shares the timer A high byte address, reached only with alt select.
// - Each qualifying capture event copies the selected timer into the data pair.
// - Each capture sets the flag, held until software clears it.
// - A new capture overwrites the old value with no overrun indication.
// - With the pin an output, a port write can produce a capture event.
// - Prescaler clears when the channel is off or capture mode is left.
// - Switching between capture prescale settings keeps the prescaler count.
// - Compare modes compare the data pair with the selected timer continuously.
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH
// ==========================================
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_DATA_LOW 8'h04
`define OFS_DATA_HIGH 8'h08
`define OFS_STATUS 8'h0C
`define OFS_TIMER_ASSIGN 8'h10
`define OFS_ALT_SELECT 8'h14
`define OFS_TIMER_A_HIGH 8'h18
// ==========================================
// Field positions and reset values
`define CTRL_MODE_LSB 0
`define CTRL_DUTY_LSB 4
`define STATUS_FLAG_BIT 0
`define CONTROL_RESET 6'h00
`define OPEN_DRAIN_RESET 5'h00
`define PRESCALE_4_LAST 4'h3
`define PRESCALE_16_LAST 4'hF
`endif

//--- pkg/ccm_pkg.sv
package ccm_pkg;
  // Mode field codes
  typedef enum logic [3:0] {
    mode_off = 4'h0,
    mode_cmp_toggle = 4'h2,
    mode_cap_fall = 4'h4,
    mode_cap_rise = 4'h5,
    mode_cap_rise4 = 4'h6,
    mode_cap_rise16 = 4'h7,
    mode_cmp_set_high = 4'h8,
    mode_cmp_set_low = 4'h9,
    mode_cmp_soft = 4'hA,
    mode_cmp_special = 4'hB
  } mode_e;
  // Control register contents
  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] mode_field;
  } control_s;
  // Timer values offered to the channel
  typedef struct packed {
    logic [15:0] timer_a_count;
    logic [15:0] timer_b_count;
    logic [7:0] period_timer_a;
    logic [7:0] period_timer_b;
  } timers_s;
endpackage

//--- rtl/capture_compare_mode_control.sv
`timescale 1ns/1ps
`include "ccm_cfg.svh"
module capture_compare_mode_control #(
  parameter int CHANNEL_INDEX = 0,
  parameter int NUM_CHANNELS = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timers and port
  input wire ccm_pkg::timers_s timers,
  input wire logic pin_direction_bit,
  input wire logic port_latch,
  input wire logic pwm_level,
  // Channel pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Status and events
  output logic channel_irq_flag,
  output logic special_event,
  output logic uses_first_pair,
  output logic [9:0] duty_value,
  output logic pwm_mode
);
  import ccm_pkg::*;

  // Refuse a channel index or count that the open-drain byte cannot serve
  if (CHANNEL_INDEX < 0 || CHANNEL_INDEX >= NUM_CHANNELS || NUM_CHANNELS > 5) begin : g_bad_params
    $error("channel index or count out of range");
  end

  // ==========================================
  // Register state
  control_s channel_control;
  logic [7:0] channel_data_low;
  logic [7:0] channel_data_high;
  logic [1:0] timer_assign;
  logic alt_register_select;
  logic [4:0] open_drain_config;
  logic cmp_level;
  logic [3:0] prescale_count;
  logic [1:0] pin_sync;
  logic pin_prev;
  logic match_prev;
  logic [3:0] mode;

  assign mode = channel_control.mode_field;

  // ==========================================
  // Bus decode: zero wait states, so a master sees pready in its first access cycle
  logic wr;
  logic rd_hit;
  logic wr_ctrl;
  logic wr_dlo;
  logic wr_dhi;
  logic wr_stat;
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign wr_ctrl = wr && paddr == `OFS_CONTROL;
  assign wr_dlo = wr && paddr == `OFS_DATA_LOW;
  assign wr_dhi = wr && paddr == `OFS_DATA_HIGH;
  assign wr_stat = wr && paddr == `OFS_STATUS;

  // Read mux; the timer A high byte window belongs to the timer unless alt select is set
  always_comb begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CONTROL: prdata[5:0] = channel_control;
      `OFS_DATA_LOW: prdata[7:0] = channel_data_low;
      `OFS_DATA_HIGH: prdata[7:0] = channel_data_high;
      `OFS_STATUS: prdata[`STATUS_FLAG_BIT] = channel_irq_flag;
      `OFS_TIMER_ASSIGN: prdata[1:0] = timer_assign;
      `OFS_ALT_SELECT: prdata[0] = alt_register_select;
      `OFS_TIMER_A_HIGH: begin
        if (alt_register_select) begin
          prdata[4:0] = open_drain_config;
        end else begin
          prdata[7:0] = timers.timer_a_count[15:8];
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~rd_hit;

  // ==========================================
  // Timer assignment: four configurations, shared per kind
  always_comb begin
    case (timer_assign)
      2'h0: uses_first_pair = 1'b1;
      2'h1: uses_first_pair = CHANNEL_INDEX == 0;
      2'h2: uses_first_pair = CHANNEL_INDEX < 2;
      default: uses_first_pair = 1'b0;
    endcase
  end
  logic [15:0] sel_timer;
  assign sel_timer = uses_first_pair ? timers.timer_a_count : timers.timer_b_count;

  // ==========================================
  // Mode decode
  logic cap_mode;
  logic cmp_mode;
  assign cap_mode = mode[3:2] == 2'b01;
  assign cmp_mode = mode == mode_cmp_toggle || mode[3:2] == 2'b10;
  assign pwm_mode = mode[3:2] == 2'b11;
  assign duty_value = {channel_data_low, channel_control.duty_low_bits};

  // ==========================================
  // Pin input: an output pin loops back its own drive so port writes can capture
  logic cap_src;
  logic rise;
  logic fall;
  assign cap_src = pin_direction_bit ? pin_sync[1] : pin_out;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 2'b00;
      pin_prev <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], pin_in};
      pin_prev <= cap_src;
    end
  end
  assign rise = cap_src & ~pin_prev & cap_mode;
  assign fall = ~cap_src & pin_prev & cap_mode;

  // Prescaler; kept across capture submodes so a switch may capture early
  logic capture;
  always_comb begin
    case (mode)
      mode_cap_fall: capture = fall;
      mode_cap_rise: capture = rise;
      mode_cap_rise4: capture = rise && prescale_count >= `PRESCALE_4_LAST;
      mode_cap_rise16: capture = rise && prescale_count == `PRESCALE_16_LAST;
      default: capture = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 4'h0;
    end else if (!cap_mode) begin
      prescale_count <= 4'h0;
    end else if (capture) begin
      prescale_count <= 4'h0;
    end else if (rise) begin
      prescale_count <= prescale_count + 4'h1;
    end
  end

  // ==========================================
  // Compare match, taken on the first cycle of equality
  logic match_now;
  logic match;
  assign match_now = cmp_mode && sel_timer == {channel_data_high, channel_data_low};
  assign match = match_now & ~match_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev <= 1'b0;
      special_event <= 1'b0;
    end else begin
      match_prev <= match_now;
      special_event <= match && mode == mode_cmp_special;
    end
  end

  // Compare output level; entry into set modes seeds the opposite level
  logic [5:0] ctrl_wdata;
  assign ctrl_wdata = pwdata[5:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_level <= 1'b0;
    end else if (wr_ctrl && ctrl_wdata[3:0] != mode) begin
      cmp_level <= ctrl_wdata[3:0] == mode_cmp_set_low;
    end else if (match) begin
      case (mode)
        mode_cmp_toggle: cmp_level <= ~cmp_level;
        mode_cmp_set_high: cmp_level <= 1'b1;
        mode_cmp_set_low: cmp_level <= 1'b0;
        default: cmp_level <= cmp_level;
      endcase
    end
  end

  // ==========================================
  // Pin drive with optional open drain
  logic drive_level;
  logic drives;
  always_comb begin
    if (pwm_mode) begin
      drive_level = pwm_level;
    end else if (mode == mode_cmp_soft || mode == mode_cmp_special || !cmp_mode) begin
      drive_level = port_latch;
    end else begin
      drive_level = cmp_level;
    end
  end
  assign drives = ~pin_direction_bit;
  always_comb begin
    if (open_drain_config[CHANNEL_INDEX] && (cmp_mode || pwm_mode)) begin
      pin_out = 1'b0;
      pin_oe = drives & ~drive_level;
    end else begin
      pin_out = drive_level;
      pin_oe = drives;
    end
  end

  // ==========================================
  // Control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control <= `CONTROL_RESET;
    end else if (wr_ctrl) begin
      channel_control <= ctrl_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_assign <= 2'h0;
      alt_register_select <= 1'b0;
      open_drain_config <= `OPEN_DRAIN_RESET;
    end else begin
      if (wr && paddr == `OFS_TIMER_ASSIGN) begin
        timer_assign <= pwdata[1:0];
      end
      if (wr && paddr == `OFS_ALT_SELECT) begin
        alt_register_select <= pwdata[0];
      end
      if (wr && paddr == `OFS_TIMER_A_HIGH && alt_register_select) begin
        open_drain_config <= pwdata[4:0];
      end
    end
  end

  // Data pair: capture beats a same-cycle bus write and overwrites silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_data_low <= 8'h00;
      channel_data_high <= 8'h00;
    end else if (capture) begin
      {channel_data_high, channel_data_low} <= sel_timer;
    end else begin
      if (wr_dlo) begin
        channel_data_low <= pwdata[7:0];
      end
      if (wr_dhi) begin
        channel_data_high <= pwdata[7:0];
      end
    end
  end

  // Flag: set wins over a write-one clear in the same cycle
  logic flag_set;
  assign flag_set = capture | (match & (cmp_mode));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_flag <= 1'b0;
    end else if (flag_set) begin
      channel_irq_flag <= 1'b1;
    end else if (wr_stat && pwdata[`STATUS_FLAG_BIT]) begin
      channel_irq_flag <= 1'b0;
    end
  end

  // ==========================================
  // Checks
  property p_capture_loads;
    @(posedge pclk) disable iff (!presetn)
    capture |=> {channel_data_high, channel_data_low} == $past(sel_timer) && channel_irq_flag;
  endproperty
  a_capture_loads: assert property (p_capture_loads) else $error("capture did not load");

  property p_flag_holds;
    @(posedge pclk) disable iff (!presetn)
    channel_irq_flag && !(wr_stat && pwdata[0]) |=> channel_irq_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

  property p_off_clears;
    @(posedge pclk) disable iff (!presetn)
    !cap_mode |=> prescale_count == 4'h0;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("prescaler not cleared");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    match && mode == mode_cmp_toggle && !wr_ctrl |=> cmp_level != $past(cmp_level);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_set_high;
    @(posedge pclk) disable iff (!presetn)
    match && mode == mode_cmp_set_high && !wr_ctrl |=> cmp_level;
  endproperty
  a_set_high: assert property (p_set_high) else $error("not forced high");

  property p_set_low;
    @(posedge pclk) disable iff (!presetn)
    match && mode == mode_cmp_set_low && !wr_ctrl |=> !cmp_level;
  endproperty
  a_set_low: assert property (p_set_low) else $error("not forced low");

  property p_special;
    @(posedge pclk) disable iff (!presetn)
    special_event |-> $past(match) && channel_irq_flag;
  endproperty
  a_special: assert property (p_special) else $error("stray special event");

  property p_rise4;
    @(posedge pclk) disable iff (!presetn)
    capture && mode == mode_cap_rise4 |-> prescale_count >= 4'h3;
  endproperty
  a_rise4: assert property (p_rise4) else $error("early prescaled capture");

  property p_soft_pin;
    @(posedge pclk) disable iff (!presetn)
    mode == mode_cmp_soft && !open_drain_config[CHANNEL_INDEX] |-> pin_out == port_latch;
  endproperty
  a_soft_pin: assert property (p_soft_pin) else $error("pin not port latch");

  // Entry into any mode but set-low starts the compare level low, mode zero included
  property p_entry_low;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && ctrl_wdata[3:0] != mode && ctrl_wdata[3:0] != mode_cmp_set_low |=> !cmp_level;
  endproperty
  a_entry_low: assert property (p_entry_low) else $error("entry level not low");

  property p_entry_high;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && ctrl_wdata[3:0] != mode && ctrl_wdata[3:0] == mode_cmp_set_low |=> cmp_level;
  endproperty
  a_entry_high: assert property (p_entry_high) else $error("entry level not high");

  property p_rise16;
    @(posedge pclk) disable iff (!presetn)
    capture && mode == mode_cap_rise16 |-> prescale_count == `PRESCALE_16_LAST;
  endproperty
  a_rise16: assert property (p_rise16) else $error("early sixteenth-edge capture");

  // Open drain may pull low or let go, but never push the pin high
  property p_od_drive;
    @(posedge pclk) disable iff (!presetn)
    open_drain_config[CHANNEL_INDEX] && (cmp_mode || pwm_mode) |-> !(pin_oe && pin_out);
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open drain drove high");

  property p_od_locked;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == `OFS_TIMER_A_HIGH && !alt_register_select |=> $stable(open_drain_config);
  endproperty
  a_od_locked: assert property (p_od_locked) else $error("open drain written without alt select");

  property p_data_write;
    @(posedge pclk) disable iff (!presetn)
    wr_dlo && !capture |=> channel_data_low == $past(pwdata[7:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data low write lost");

  property p_special_pulse;
    @(posedge pclk) disable iff (!presetn)
    special_event |=> !special_event;
  endproperty
  a_special_pulse: assert property (p_special_pulse) else $error("special event too long");

  // Edge detector must give one event per pin edge
  property p_edge_single;
    @(posedge pclk) disable iff (!presetn)
    rise |=> !rise;
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("rise event repeated");

  c_capture: cover property (@(posedge pclk) disable iff (!presetn) capture);
  c_match: cover property (@(posedge pclk) disable iff (!presetn) match);
  c_special: cover property (@(posedge pclk) disable iff (!presetn) special_event);
  c_rise16: cover property (@(posedge pclk) disable iff (!presetn) capture && mode == mode_cap_rise16);
  c_od_release: cover property (@(posedge pclk) disable iff (!presetn)
    open_drain_config[CHANNEL_INDEX] && (cmp_mode || pwm_mode) && !pin_oe);
endmodule

//--- verif/pin_partner.sv
`timescale 1ns/1ps
// ==========================================
// External source and load on the channel pin
module pin_partner (
  // Pad side of the channel
  input wire logic pin_out,
  input wire logic pin_oe,
  // Far-side source level
  input wire logic src_level,
  output logic pin_in
);
  // The channel drive wins while enabled; otherwise the outside source sets the wire
  assign pin_in = pin_oe ? pin_out : src_level;
endmodule

//--- verif/test_capture_compare_mode_control.sv
`timescale 1ns/1ps
`include "ccm_cfg.svh"
module test_capture_compare_mode_control;
  import ccm_pkg::*;
  // ==========================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, src_level;
  logic pin_direction_bit, port_latch, pwm_level, pin_in, pin_out, pin_oe;
  logic channel_irq_flag, special_event, uses_first_pair, pwm_mode, uses_first_pair_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] duty_value;
  timers_s timers;
  int fail_count = 0;
  int cmp_count = 0;
  int ones;
  // Compare modes with pin level on entry and after the match (port latch held low)
  logic [3:0] cm_mode [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
  logic ent [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic hit [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  capture_compare_mode_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timers(timers), .pin_direction_bit(pin_direction_bit), .port_latch(port_latch), .pwm_level(pwm_level),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .channel_irq_flag(channel_irq_flag),
    .special_event(special_event), .uses_first_pair(uses_first_pair), .duty_value(duty_value),
    .pwm_mode(pwm_mode));
  pin_partner i_pin (.pin_out(pin_out), .pin_oe(pin_oe), .src_level(src_level), .pin_in(pin_in));
  // Second channel on the same bus, only to tell the timer-assignment cases apart
  capture_compare_mode_control #(.CHANNEL_INDEX(1)) i_dut_b (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .timers(timers), .pin_direction_bit(pin_direction_bit), .port_latch(port_latch), .pwm_level(pwm_level),
    .pin_in(src_level), .pin_out(), .pin_oe(), .channel_irq_flag(), .special_event(),
    .uses_first_pair(uses_first_pair_b), .duty_value(), .pwm_mode());

  // ==========================================
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================
  // Helpers
  task automatic close_out;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen high in the access phase
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1); // Only the watchdog ends a hung wait
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Rising then falling edge on the pin, each held long enough to pass the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk) src_level <= 1'b1;
      repeat (4) @(posedge pclk);
      src_level <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    #1;
  endtask
  // Mode change then flag clear, since a mode change may raise a false flag
  task automatic setmode(input logic [5:0] c);
    wr(`OFS_CONTROL, {26'h0, c});
    wr(`OFS_STATUS, 32'h1);
  endtask

  // ==========================================
  // Tests
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, port_latch, pwm_level, src_level} = '0;
    timers = '0;
    pin_direction_bit = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("control reset", `OFS_CONTROL, 32'h0);
    rdchk("status reset", `OFS_STATUS, 32'h0);
    // Rising-edge capture, then an overwrite with no overrun
    timers.timer_a_count <= 16'h1234;
    setmode({2'b00, mode_cap_rise});
    pulses(1);
    chk("flag", 1, channel_irq_flag);
    rdchk("data low", `OFS_DATA_LOW, 32'h34);
    rdchk("data high", `OFS_DATA_HIGH, 32'h12);
    @(posedge pclk) timers.timer_a_count <= 16'hBEEF;
    pulses(1);
    rdchk("data low", `OFS_DATA_LOW, 32'hEF);
    rdchk("data high", `OFS_DATA_HIGH, 32'hBE);
    wr(`OFS_STATUS, 32'h1);
    cyc(1);
    chk("flag", 0, channel_irq_flag);
    // Falling-edge capture ignores the rise
    setmode({2'b00, mode_cap_fall});
    @(posedge pclk) src_level <= 1'b1;
    cyc(7);
    chk("flag", 0, channel_irq_flag);
    @(posedge pclk) src_level <= 1'b0;
    cyc(7);
    chk("flag", 1, channel_irq_flag);
    // Prescale by four, then a direct switch to sixteen keeps the count
    setmode({2'b00, mode_cap_rise4});
    pulses(3);
    chk("flag", 0, channel_irq_flag);
    pulses(1);
    chk("flag", 1, channel_irq_flag);
    wr(`OFS_STATUS, 32'h1);
    pulses(2);
    setmode({2'b00, mode_cap_rise16});
    pulses(13);
    chk("flag", 0, channel_irq_flag);
    pulses(1);
    chk("flag", 1, channel_irq_flag);
    // Turning the channel off clears a partial count
    setmode({2'b00, mode_cap_rise16});
    pulses(3);
    setmode({2'b00, mode_off});
    setmode({2'b00, mode_cap_rise16});
    pulses(15);
    chk("flag", 0, channel_irq_flag);
    pulses(1);
    chk("flag", 1, channel_irq_flag);
    // Timer assignment cases, and a capture from the second timer
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_TIMER_ASSIGN, i);
      cyc(1);
      chk("first pair", i != 3, uses_first_pair);
      chk("first pair b", i == 0 || i == 2, uses_first_pair_b);
    end
    @(posedge pclk) timers.timer_b_count <= 16'h5A5A;
    setmode({2'b00, mode_cap_rise});
    pulses(1);
    rdchk("data low", `OFS_DATA_LOW, 32'h5A);
    // Compare modes against timer A
    pin_direction_bit <= 1'b0;
    wr(`OFS_TIMER_ASSIGN, 32'h0);
    wr(`OFS_DATA_LOW, 32'h50);
    wr(`OFS_DATA_HIGH, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk) timers.timer_a_count <= 16'h0;
      setmode({2'b00, cm_mode[i]});
      cyc(2);
      chk("entry pin", ent[i], pin_out);
      chk("pin drive", 1, pin_oe);
      ones = 0;
      @(posedge pclk) timers.timer_a_count <= 16'h0050;
      repeat (4) begin
        @(posedge pclk);
        #1;
        ones += (special_event === 1'b1);
      end
      chk("match pin", hit[i], pin_out);
      chk("flag", 1, channel_irq_flag);
      chk("special", cm_mode[i] == 4'hB, ones);
    end
    // Open-drain register behind the alternate select
    @(posedge pclk) timers.timer_a_count <= 16'hA500;
    wr(`OFS_ALT_SELECT, 32'h0);
    wr(`OFS_TIMER_A_HIGH, 32'h1);
    rdchk("timer high", `OFS_TIMER_A_HIGH, 32'hA5);
    wr(`OFS_ALT_SELECT, 32'h1);
    rdchk("open drain", `OFS_TIMER_A_HIGH, 32'h0);
    wr(`OFS_TIMER_A_HIGH, 32'h1);
    rdchk("open drain", `OFS_TIMER_A_HIGH, 32'h1);
    @(posedge pclk) timers.timer_a_count <= 16'h0;
    setmode({2'b00, mode_cmp_set_high});
    cyc(2);
    chk("od low drive", 2'b01, {pin_out, pin_oe});
    @(posedge pclk) timers.timer_a_count <= 16'h0050;
    cyc(4);
    chk("od release", 0, pin_oe);
    // PWM duty assembly and register read-back
    wr(`OFS_DATA_LOW, 32'hAB);
    setmode(6'h3C);
    cyc(1);
    chk("duty", 10'h2AF, duty_value);
    chk("pwm mode", 1, pwm_mode);
    @(posedge pclk) pwm_level <= 1'b1;
    cyc(1);
    chk("od pwm release", 0, pin_oe);
    @(posedge pclk) pwm_level <= 1'b0;
    cyc(1);
    chk("od pwm low", 2'b01, {pin_out, pin_oe});
    rdchk("control", `OFS_CONTROL, 32'h3C);
    rdchk("data low", `OFS_DATA_LOW, 32'hAB);
    // Port write loops back as a capture while the pin is an output
    setmode({2'b00, mode_cap_rise});
    cyc(6);
    wr(`OFS_STATUS, 32'h1);
    @(posedge pclk) port_latch <= 1'b1;
    cyc(7);
    chk("flag", 1, channel_irq_flag);
    // Unmapped address is refused
    apb(1'b1, 8'h1C, 32'h0);
    chk("slverr", 1, err);
    rdchk("control", `OFS_CONTROL, 32'h05);
    close_out;
  end

  // ==========================================
  // Watchdog
  initial begin
    #200000;
    fail_count++;
    close_out;
  end
endmodule
